// ### csc_pkg.sv
// Package of constants and types for the clock source and synth control
package csc_pkg;

  // Bus clock and nominal oscillator rates
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned RC_HZ = 32768;
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned RC_DIV = CLK_HZ / RC_HZ;
  localparam logic [11:0] RC_DIV_LAST = 12'(RC_DIV - 1);

  // Full-speed synth rates at 50 Hz grid
  localparam longint unsigned CPU_FULL_HZ = 64'd13107200;
  localparam longint unsigned METER_FULL_HZ = 64'd3276800;
  localparam logic [31:0] CPU_STEP = 32'((CPU_FULL_HZ << 32) / CLK_HZ);
  localparam logic [31:0] METER_STEP = 32'((METER_FULL_HZ << 32) / CLK_HZ);
  localparam logic [1:0] CONV_DIV_LAST = 2'h3;

  // Crystal monitor and lock timing, in oscillator ticks
  localparam logic [3:0] XTAL_FAIL_RC_TICKS = 4'h3;
  localparam logic [3:0] XTAL_GOOD_TICKS = 4'h8;
  localparam logic [3:0] LOCK_XTAL_TICKS = 4'h4;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_SYSCTL = 14'h0080;
  localparam logic [13:0] IDX_LOCK = 14'h00A3;
  localparam logic [13:0] IDX_TRIM = 14'h2860;
  localparam logic [13:0] IDX_CFG = 14'h2867;
  localparam logic [13:0] IDX_SYNTH = 14'h2868;
  localparam logic [13:0] IDX_ASTATE = 14'h286B;
  localparam logic [13:0] IDX_PINFN = 14'h28C9;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h3000;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h3001;

  // Field positions
  localparam int SYS_CPU_SEL = 0;
  localparam int SYS_CPU_OFF = 1;
  localparam int SYS_METER_OFF = 4;
  localparam int SYS_METER_SEL = 7;
  localparam int CFG_SYNTH_EN = 0;
  localparam int CFG_CPU_DIV_LO = 1;
  localparam int CFG_METER_DIV_LO = 4;
  localparam int SYN_DISP_OFF = 0;
  localparam int SYN_GRID60 = 5;
  localparam int AST_XTAL_FAIL = 7;
  localparam int PIN_XTAL_OUT = 0;
  localparam int IRQ_XTAL_FAIL = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_XTAL_BACK = 2;

  // Reset values
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] SYNTH_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] PINFN_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Domain clock enables, one pclk cycle per domain edge
  typedef struct packed {
    logic cpu_domain_clock;
    logic meter_domain_clock;
    logic display_clock;
    logic watchdog_clock;
    logic calendar_clock;
    logic converter_clock;
  } csc_ticks_s;

  // Monitor states
  typedef enum logic [1:0] {
    CSC_XTAL_OK = 2'b01,
    CSC_XTAL_FAIL = 2'b10
  } csc_mon_e;

endpackage : csc_pkg

// ### csc_tick_mux.sv
// Glitch-free two-source tick selector with gate
`timescale 1ns/1ns
module csc_tick_mux
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sources and control
  input wire logic tick_a,
  input wire logic tick_b,
  input wire logic sel_b,
  input wire logic enable,
  // Selected tick
  output logic tick_out
);

  logic cur_b;
  logic cur_en;
  wire quiet = !tick_a && !tick_b;
  wire src_tick = cur_b ? tick_b : tick_a;

  // Change source or gate only between pulses, so no runt appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_b <= 1'b0;
      cur_en <= 1'b1;
      tick_out <= 1'b0;
    end else begin
      if (quiet) begin
        cur_b <= sel_b;
        cur_en <= enable;
      end
      tick_out <= src_tick && cur_en;
    end
  end

endmodule : csc_tick_mux

// ### csc_clock_ctrl.sv
// Clock source, crystal monitor, synth and domain gating with APB registers
// Operation
// - RC oscillator always runs; watchdog clock from it, gated with cpu clock
// - RC-clocked monitor substitutes RC for crystal on a crystal stop
// - Monitor keeps stimulating the crystal while it is stopped
// - Crystal failure flag readable at bit 7 of analog state register
// - Cpu clock selects crystal or synth, on after reset, gateable off
// - Meter clock selects crystal or synth, on after reset, gateable off
// - Display clock from crystal; off only when both domains use synth
// - Calendar clock from crystal and never gated
// - Synth locks to crystal multiple; meter, cpu and converter outputs
// - Disabled synth outputs the 32768 Hz crystal clock
// - Select bits 0 and 7 switch the domain within one synth cycle
// - Grid select bit 5 scales synth outputs by 1.2; reset is 50 Hz
// - Full speed: cpu 13.1072 MHz, meter 3.2768 MHz, converter quarter
// - Pin function register routes crystal clock onto pin P2.0
`timescale 1ns/1ns
module csc_clock_ctrl
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Crystal oscillator
  input wire logic crystal_osc_in,
  output logic crystal_kick,
  // Pin P2.0 observation output
  output logic pin_p20_out,
  output logic pin_p20_oe_n,
  // Domain clock enables
  output csc_ticks_s domain_ticks,
  output logic synth_meter_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] system_control_reg;
  logic [7:0] clock_config_reg;
  logic [7:0] synth_control_reg;
  logic [7:0] crystal_trim_reg;
  logic [7:0] pin_function_select_reg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;

  // Oscillator and monitor state
  logic [11:0] rc_cnt;
  logic rc_osc_clock;
  logic xtal_s1;
  logic xtal_s2;
  logic xtal_s3;
  csc_mon_e mon_state;
  logic [3:0] miss_cnt;
  logic [3:0] good_cnt;
  logic [3:0] lock_cnt;
  logic lock_indicator;
  logic [31:0] cpu_acc;
  logic [31:0] meter_acc;
  logic synth_cpu_raw;
  logic synth_meter_raw;
  logic [1:0] conv_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [13:0] idx = paddr[15:2];
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_sys = idx == IDX_SYSCTL;
  wire hit_lock = idx == IDX_LOCK;
  wire hit_trim = idx == IDX_TRIM;
  wire hit_cfg = idx == IDX_CFG;
  wire hit_syn = idx == IDX_SYNTH;
  wire hit_ast = idx == IDX_ASTATE;
  wire hit_pin = idx == IDX_PINFN;
  wire hit_ist = idx == IDX_IRQ_STAT;
  wire hit_imk = idx == IDX_IRQ_MASK;
  wire mapped = hit_sys || hit_lock || hit_trim || hit_cfg || hit_syn ||
                hit_ast || hit_pin || hit_ist || hit_imk;

  wire xtal_failed = mon_state == CSC_XTAL_FAIL;
  wire [7:0] astate_val = {xtal_failed, 7'h00};
  wire [31:0] rd_mux =
    hit_sys ? {24'h000000, system_control_reg} :
    hit_lock ? {31'h00000000, lock_indicator} :
    hit_trim ? {24'h000000, crystal_trim_reg} :
    hit_cfg ? {24'h000000, clock_config_reg} :
    hit_syn ? {24'h000000, synth_control_reg} :
    hit_ast ? {24'h000000, astate_val} :
    hit_pin ? {24'h000000, pin_function_select_reg} :
    hit_ist ? {29'h00000000, irq_status} :
    hit_imk ? {29'h00000000, irq_mask} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Writable registers; trim field is stored for the crystal cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_reg <= SYSCTL_RST;
      clock_config_reg <= CFG_RST;
      synth_control_reg <= SYNTH_RST;
      crystal_trim_reg <= TRIM_RST;
      pin_function_select_reg <= PINFN_RST;
      irq_mask <= IRQ_RST;
    end else if (wr) begin
      if (hit_sys) system_control_reg <= pwdata[7:0];
      if (hit_cfg) clock_config_reg <= pwdata[7:0];
      if (hit_syn) synth_control_reg <= pwdata[7:0];
      if (hit_trim) crystal_trim_reg <= pwdata[7:0];
      if (hit_pin) pin_function_select_reg <= pwdata[7:0];
      if (hit_imk) irq_mask <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RC oscillator, free running from reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_cnt <= 12'h000;
      rc_osc_clock <= 1'b0;
    end else begin
      rc_osc_clock <= rc_cnt == RC_DIV_LAST;
      rc_cnt <= (rc_cnt == RC_DIV_LAST) ? 12'h000 : rc_cnt + 12'h001;
    end
  end

  // Crystal pin synchroniser and rising edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
    end else begin
      xtal_s1 <= crystal_osc_in;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
    end
  end
  wire xtal_edge = xtal_s2 && !xtal_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Crystal monitor: misses counted on RC ticks, recovery counted on crystal edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_state <= CSC_XTAL_OK;
      miss_cnt <= 4'h0;
      good_cnt <= 4'h0;
    end else begin
      if (xtal_edge) begin
        miss_cnt <= 4'h0;
      end else if (rc_osc_clock && miss_cnt != XTAL_FAIL_RC_TICKS) begin
        miss_cnt <= miss_cnt + 4'h1;
      end
      case (mon_state)
        CSC_XTAL_OK: begin
          good_cnt <= 4'h0;
          if (rc_osc_clock && miss_cnt == XTAL_FAIL_RC_TICKS) begin
            mon_state <= CSC_XTAL_FAIL;
          end
        end
        CSC_XTAL_FAIL: begin
          // Several clean edges needed, so a sputtering crystal is ignored
          if (miss_cnt == XTAL_FAIL_RC_TICKS) begin
            good_cnt <= 4'h0;
          end else if (xtal_edge && good_cnt != XTAL_GOOD_TICKS) begin
            good_cnt <= good_cnt + 4'h1;
          end
          if (good_cnt == XTAL_GOOD_TICKS) begin
            mon_state <= CSC_XTAL_OK;
          end
        end
        default: mon_state <= CSC_XTAL_OK;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_kick <= 1'b0;
    end else begin
      crystal_kick <= xtal_failed && rc_osc_clock;
    end
  end

  // Crystal-rate tick with RC substitution
  wire xtal_tick = xtal_failed ? rc_osc_clock : xtal_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer: phase accumulators locked to the crystal rate
  wire synth_en = clock_config_reg[CFG_SYNTH_EN];
  wire grid60 = synth_control_reg[SYN_GRID60];
  wire [2:0] cpu_div = clock_config_reg[CFG_CPU_DIV_LO +: 3];
  wire [2:0] meter_div = clock_config_reg[CFG_METER_DIV_LO +: 3];
  wire [31:0] cpu_base = CPU_STEP >> cpu_div;
  wire [31:0] meter_base = METER_STEP >> meter_div;
  wire [31:0] cpu_step = grid60 ? cpu_base + cpu_base / 32'd5 : cpu_base;
  wire [31:0] meter_step =
    grid60 ? meter_base + meter_base / 32'd5 : meter_base;
  wire [32:0] cpu_sum = {1'b0, cpu_acc} + {1'b0, cpu_step};
  wire [32:0] meter_sum = {1'b0, meter_acc} + {1'b0, meter_step};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_acc <= 32'h00000000;
      meter_acc <= 32'h00000000;
      synth_cpu_raw <= 1'b0;
      synth_meter_raw <= 1'b0;
    end else if (synth_en) begin
      cpu_acc <= cpu_sum[31:0];
      meter_acc <= meter_sum[31:0];
      synth_cpu_raw <= cpu_sum[32];
      synth_meter_raw <= meter_sum[32];
    end else begin
      cpu_acc <= 32'h00000000;
      meter_acc <= 32'h00000000;
      synth_cpu_raw <= 1'b0;
      synth_meter_raw <= 1'b0;
    end
  end

  // Lock after a fixed number of crystal ticks from enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 4'h0;
      lock_indicator <= 1'b0;
    end else if (!synth_en) begin
      lock_cnt <= 4'h0;
      lock_indicator <= 1'b0;
    end else if (xtal_tick && lock_cnt != LOCK_XTAL_TICKS) begin
      lock_cnt <= lock_cnt + 4'h1;
    end else if (lock_cnt == LOCK_XTAL_TICKS) begin
      lock_indicator <= 1'b1;
    end
  end

  // Disabled synth hands the crystal clock through
  wire synth_cpu = synth_en ? synth_cpu_raw : xtal_tick;
  wire synth_meter = synth_en ? synth_meter_raw : xtal_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Domain selection and gating
  wire cpu_sel = system_control_reg[SYS_CPU_SEL];
  wire meter_sel = system_control_reg[SYS_METER_SEL];
  wire cpu_on = !system_control_reg[SYS_CPU_OFF];
  wire meter_on = !system_control_reg[SYS_METER_OFF];
  // Display gate honoured only with both domains on the synth
  wire disp_on = !(synth_control_reg[SYN_DISP_OFF] && cpu_sel &&
                   meter_sel);
  logic meter_tick;

  csc_tick_mux u_cpu_mux (
    .pclk(pclk),
    .presetn(presetn),
    .tick_a(xtal_tick),
    .tick_b(synth_cpu),
    .sel_b(cpu_sel),
    .enable(cpu_on),
    .tick_out(domain_ticks.cpu_domain_clock)
  );

  csc_tick_mux u_meter_mux (
    .pclk(pclk),
    .presetn(presetn),
    .tick_a(xtal_tick),
    .tick_b(synth_meter),
    .sel_b(meter_sel),
    .enable(meter_on),
    .tick_out(meter_tick)
  );

  csc_tick_mux u_disp_mux (
    .pclk(pclk),
    .presetn(presetn),
    .tick_a(xtal_tick),
    .tick_b(1'b0),
    .sel_b(1'b0),
    .enable(disp_on),
    .tick_out(domain_ticks.display_clock)
  );

  csc_tick_mux u_wdt_mux (
    .pclk(pclk),
    .presetn(presetn),
    .tick_a(rc_osc_clock),
    .tick_b(1'b0),
    .sel_b(1'b0),
    .enable(cpu_on),
    .tick_out(domain_ticks.watchdog_clock)
  );

  csc_tick_mux u_cal_mux (
    .pclk(pclk),
    .presetn(presetn),
    .tick_a(xtal_tick),
    .tick_b(1'b0),
    .sel_b(1'b0),
    .enable(1'b1),
    .tick_out(domain_ticks.calendar_clock)
  );

  // Converter clock is a quarter of the meter clock, on its fourth tick
  wire conv_tick = meter_tick && conv_cnt == CONV_DIV_LAST;
  assign domain_ticks.meter_domain_clock = meter_tick;
  assign domain_ticks.converter_clock = conv_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt <= 2'h0;
      synth_meter_out <= 1'b0;
    end else begin
      synth_meter_out <= synth_meter;
      if (meter_tick) begin
        conv_cnt <= conv_cnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal observation on P2.0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_p20_out <= 1'b0;
      pin_p20_oe_n <= 1'b1;
    end else begin
      pin_p20_out <= xtal_s2;
      pin_p20_oe_n <= !pin_function_select_reg[PIN_XTAL_OUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: hardware set wins over write-one clear
  logic fail_d;
  logic lock_d;
  wire [2:0] irq_set = {fail_d && !xtal_failed,
                        lock_indicator && !lock_d,
                        xtal_failed && !fail_d};
  wire [2:0] irq_clr = (wr && hit_ist) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_d <= 1'b0;
      lock_d <= 1'b0;
      irq_status <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      fail_d <= xtal_failed;
      lock_d <= lock_indicator;
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : csc_clock_ctrl

// ### csc_clock_ctrl_props.sv
// Assertion checker for the clock source and synth control block
`timescale 1ns/1ns
module csc_clock_ctrl_props
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Crystal and pin
  input wire logic crystal_osc_in,
  input wire logic crystal_kick,
  input wire logic pin_p20_out,
  input wire logic pin_p20_oe_n,
  // Domain ticks and interrupt
  input wire csc_ticks_s domain_ticks,
  input wire logic synth_meter_out,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  ////////////////////////////////////////////////////////////////////////////
  chk_slverr_in_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  chk_unmapped_reads_zero: assert property (acc && !pwrite && pslverr
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_sysctl_mapped: assert property (acc && paddr == 16'h0200 |-> !pslverr)
    else $error("system control refused");
  chk_kick_spacing: assert property (crystal_kick |=> !crystal_kick [*8])
    else $error("kick pulses too close");
  chk_wdog_spacing: assert property (domain_ticks.watchdog_clock
    |=> !domain_ticks.watchdog_clock [*8]) else $error("watchdog too fast");
  chk_conv_on_meter: assert property (domain_ticks.converter_clock
    |-> domain_ticks.meter_domain_clock) else $error("converter unpaired");
  chk_cpu_no_runt: assert property (domain_ticks.cpu_domain_clock
    |=> !domain_ticks.cpu_domain_clock) else $error("cpu tick runt");
  chk_pin_drive_on: assert property (wr && paddr == 16'hA324 && pwdata[0]
    |-> ##[1:2] !pin_p20_oe_n) else $error("pin not driven");
  chk_irq_masked_off: assert property (wr && paddr == 16'hC004
    && pwdata[2:0] == 3'h0 |-> ##2 !irq) else $error("masked irq high");
  ////////////////////////////////////////////////////////////////////////////
  cover property (crystal_kick);
  cover property (domain_ticks.converter_clock);
  cover property (irq);
endmodule : csc_clock_ctrl_props

bind csc_clock_ctrl csc_clock_ctrl_props u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .crystal_osc_in(crystal_osc_in),
  .crystal_kick(crystal_kick), .pin_p20_out(pin_p20_out),
  .pin_p20_oe_n(pin_p20_oe_n), .domain_ticks(domain_ticks),
  .synth_meter_out(synth_meter_out), .irq(irq));

// ### tb.sv
// Self-checking testbench for the clock source and synth control block
`timescale 1ns/1ns
module tb;
  import csc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic crystal_osc_in = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic crystal_kick;
  logic pin_p20_out;
  logic pin_p20_oe_n;
  csc_ticks_s domain_ticks;
  logic synth_meter_out;
  logic irq;
  logic xtal_run = 1'b1;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int xcnt = 0;
  int cnt [7];
  int i;
  logic [13:0] ridx [9] = '{IDX_SYSCTL, IDX_LOCK, IDX_TRIM, IDX_CFG,
    IDX_SYNTH, IDX_ASTATE, IDX_PINFN, IDX_IRQ_STAT, IDX_IRQ_MASK};

  csc_clock_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_osc_in(crystal_osc_in), .crystal_kick(crystal_kick),
    .pin_p20_out(pin_p20_out), .pin_p20_oe_n(pin_p20_oe_n),
    .domain_ticks(domain_ticks), .synth_meter_out(synth_meter_out),
    .irq(irq));

  always #4 pclk = ~pclk;

  // Crystal near 32768 Hz; when stopped it just holds its level
  always @(posedge pclk) begin
    xcnt <= (xcnt == 1906) ? 0 : xcnt + 1;
    if (xtal_run && xcnt == 1906) begin
      crystal_osc_in <= ~crystal_osc_in;
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Slow events are polled, bounded by the run timeout as well
  task automatic poll(input logic [13:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
    int n;
    n = 0;
    apb(1'b0, idx, 32'h0);
    while ((rd & m) !== exp && n < 800) begin
      repeat (50) @(posedge pclk);
      apb(1'b0, idx, 32'h0);
      n++;
    end
  endtask : poll

  // Samples at the falling edge, where registered ticks have settled
  task automatic count(input int n);
    for (int k = 0; k < 7; k++) begin
      cnt[k] = 0;
    end
    // Gate and select changes wait for a quiet source cycle
    repeat (4) @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      for (int k = 0; k < 6; k++) begin
        cnt[k] += int'(domain_ticks[5-k]);
      end
      cnt[6] += int'(synth_meter_out);
    end
    @(posedge pclk);
  endtask : count

  function automatic logic [31:0] in_rng(input int k, input int lo,
                                         input int hi);
    return 32'(cnt[k] >= lo && cnt[k] <= hi);
  endfunction : in_rng

  task automatic irq_is(input logic exp);
    @(negedge pclk);
    chk(32'(irq), 32'(exp));
    @(posedge pclk);
  endtask : irq_is
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ridx[k]) begin
      rdchk(ridx[k], 32'h0);
    end
    apb(1'b0, 14'h0001, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b1, IDX_ASTATE, 32'h80);
    rdchk(IDX_ASTATE, 32'h0);
    apb(1'b1, IDX_TRIM, 32'h3);
    rdchk(IDX_TRIM, 32'h3);
    apb(1'b1, IDX_PINFN, 32'h1);
    irq_is(1'b0);
    chk(32'(pin_p20_oe_n), 32'h0);
    // Mid crystal half period, so the pin has settled
    @(posedge pclk iff xcnt == 900);
    chk(32'(pin_p20_out), 32'(crystal_osc_in));
    apb(1'b1, IDX_IRQ_MASK, 32'h7);
    count(4000);
    chk(in_rng(0, 1, 2), 32'h1);
    chk(in_rng(1, 1, 2), 32'h1);
    chk(in_rng(2, 1, 2), 32'h1);
    chk(in_rng(3, 1, 2), 32'h1);
    chk(in_rng(4, 1, 2), 32'h1);
    chk(in_rng(6, 1, 2), 32'h1);
    // Synth enabled only after the cpu runs on crystal
    apb(1'b1, IDX_CFG, 32'h1);
    poll(IDX_LOCK, 32'h1, 32'h1);
    chk(rd, 32'h1);
    irq_is(1'b1);
    rdchk(IDX_IRQ_STAT, 32'h2);
    apb(1'b1, IDX_IRQ_MASK, 32'h5);
    irq_is(1'b0);
    apb(1'b1, IDX_IRQ_STAT, 32'h2);
    rdchk(IDX_IRQ_STAT, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 32'h7);
    apb(1'b1, IDX_SYSCTL, 32'h81);
    count(1000);
    chk(in_rng(0, 104, 106), 32'h1);
    chk(in_rng(1, 26, 27), 32'h1);
    chk(in_rng(5, 6, 7), 32'h1);
    apb(1'b1, IDX_SYNTH, 32'h1);
    count(4000);
    chk(in_rng(2, 0, 0), 32'h1);
    // Display-off must be ignored once the meter leaves the synth
    apb(1'b1, IDX_SYSCTL, 32'h1);
    count(4000);
    chk(in_rng(2, 1, 2), 32'h1);
    apb(1'b1, IDX_SYSCTL, 32'h0);
    apb(1'b1, IDX_CFG, 32'h3);
    apb(1'b1, IDX_SYSCTL, 32'h1);
    count(1000);
    chk(in_rng(0, 52, 53), 32'h1);
    apb(1'b1, IDX_SYSCTL, 32'h0);
    apb(1'b1, IDX_CFG, 32'h1);
    apb(1'b1, IDX_SYNTH, 32'h20);
    apb(1'b1, IDX_SYSCTL, 32'h81);
    count(1000);
    chk(in_rng(0, 125, 127), 32'h1);
    chk(in_rng(1, 31, 32), 32'h1);
    apb(1'b1, IDX_SYSCTL, 32'h12);
    count(4000);
    chk(in_rng(0, 0, 0), 32'h1);
    chk(in_rng(3, 0, 0), 32'h1);
    chk(in_rng(1, 0, 0), 32'h1);
    chk(in_rng(4, 1, 2), 32'h1);
    apb(1'b1, IDX_SYSCTL, 32'h0);
    apb(1'b1, IDX_CFG, 32'h0);
    // Crystal stops: substitution, flag, interrupt and restart pulses
    xtal_run <= 1'b0;
    i = 0;
    while (crystal_kick !== 1'b1 && i < 25000) begin
      @(negedge pclk);
      i++;
    end
    chk(32'(crystal_kick), 32'h1);
    @(posedge pclk);
    rdchk(IDX_ASTATE, 32'h80);
    rdchk(IDX_IRQ_STAT, 32'h1);
    irq_is(1'b1);
    count(4000);
    chk(in_rng(4, 1, 2), 32'h1);
    chk(in_rng(0, 1, 2), 32'h1);
    chk(in_rng(6, 1, 2), 32'h1);
    xtal_run <= 1'b1;
    poll(IDX_ASTATE, 32'h80, 32'h0);
    chk(rd, 32'h0);
    rdchk(IDX_IRQ_STAT, 32'h5);
    apb(1'b1, IDX_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    give_verdict();
  end
endmodule : tb
